/* File: rtl/anx_expansion_status.sv */
// Summary of operation
// - Reserved upper expansion bits always read back as zero.
// - Reserved-bit writes take effect only while the override bit is one.
// - Parallel detection fault flag rises when partner technology is ambiguous.
// - Parallel detection fault flag latches high once the fault occurs.
// - Partner next-page flag mirrors next page bit of received base word.
// - Local next-page capability reads one, also straight after reset.
// - Page-received flag sets when a new code word is stored.
// - Reading the expansion register clears the page-received flag.
// - Partner negotiation-able flag stays zero until valid bursts arrive.
// - Partner ability register loads from the received link code word.
`timescale 1ns/1ns
`default_nettype none
module anx_expansion_status (
  // Clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Avalon-MM slave
  input  wire logic [5:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  // Negotiation engine status
  input  wire logic        pd_fault_i,
  input  wire logic        flp_valid_i,
  input  wire logic        page_rx_i,
  input  wire logic [15:0] page_word_i,
  // Interrupt
  output logic             irq_o
);

  typedef struct packed {
    logic        pd_fault;
    logic        pd_seen;
    logic        page_rx;
    logic        lp_np;
    logic        lp_an;
    logic [10:0] rsvd;
    logic [15:0] partner;
    logic        override;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        rd_pend;
    logic [31:0] rdata;
  } anx_state_type;

  anx_state_type state_q;
  anx_state_type state_d;
  logic [3:0]    idx;
  logic          addr_ok;
  logic [15:0]   exp_word;
  logic          wr_lo;
  logic          wr_hi;
  logic          rd_take;
  logic          exp_read;

  assign idx      = address_i[5:2];
  assign addr_ok  = (address_i[1:0] == 2'h0);
  assign wr_lo    = write_i && byteenable_i[0];
  assign wr_hi    = write_i && byteenable_i[1];
  // A read stalls one cycle so the read side effect lands exactly once.
  assign rd_take  = read_i && state_q.rd_pend;
  assign exp_read = rd_take && addr_ok && (idx == anx_pkg::EXPANSION_IDX);
  // While the clock enable is low nothing is taken, so the master is held off.
  assign waitrequest_o = !ce_i || (read_i && !state_q.rd_pend);
  assign readdata_o    = state_q.rdata;
  assign irq_o         = |(state_q.irq_stat & state_q.irq_mask);

  always_comb begin
    exp_word = anx_pkg::WORD_RESET;
    exp_word[anx_pkg::PD_FAULT_BIT] = state_q.pd_fault;
    exp_word[anx_pkg::LP_NP_BIT]    = state_q.lp_np;
    exp_word[anx_pkg::LOCAL_NP_BIT] = anx_pkg::LOCAL_NP_RESET;
    exp_word[anx_pkg::PAGE_RX_BIT]  = state_q.page_rx;
    exp_word[anx_pkg::LP_AN_BIT]    = state_q.lp_an;
  end

  always_comb begin
    state_d = state_q;
    state_d.rd_pend = read_i && !state_q.rd_pend;
    // Latched fault: sticky until read, which reloads it from the live condition.
    if (exp_read) begin
      state_d.pd_fault = pd_fault_i;
      state_d.page_rx  = page_rx_i;
    end else begin
      state_d.pd_fault = state_q.pd_fault | pd_fault_i;
      state_d.page_rx  = state_q.page_rx | page_rx_i;
    end
    if (page_rx_i) begin
      state_d.partner = page_word_i;
      state_d.lp_np   = page_word_i[anx_pkg::PARTNER_NP_BIT];
    end
    if (flp_valid_i) begin
      state_d.lp_an = 1'b1;
    end
    if (write_i && addr_ok) begin
      case (idx)
        anx_pkg::EXPANSION_IDX: begin
          // Reserved bits are held but never returned on reads.
          if (state_q.override) begin
            if (wr_lo) state_d.rsvd[2:0]  = writedata_i[7:5];
            if (wr_hi) state_d.rsvd[10:3] = writedata_i[15:8];
          end
        end
        anx_pkg::CONTROL_IDX: begin
          if (wr_hi) state_d.override = writedata_i[anx_pkg::OVERRIDE_BIT];
        end
        anx_pkg::IRQ_MASK_IDX: begin
          if (wr_lo) state_d.irq_mask = writedata_i[2:0];
        end
        anx_pkg::IRQ_STATUS_IDX: begin
          if (wr_lo) state_d.irq_stat = state_q.irq_stat & ~writedata_i[2:0];
        end
        default: begin
        end
      endcase
    end
    // Events win over a simultaneous write-one-to-clear.
    if (pd_fault_i) state_d.irq_stat[anx_pkg::IRQ_FAULT_BIT] = 1'b1;
    if (page_rx_i)  state_d.irq_stat[anx_pkg::IRQ_PAGE_BIT]  = 1'b1;
    if (flp_valid_i && !state_q.lp_an) state_d.irq_stat[anx_pkg::IRQ_AN_BIT] = 1'b1;
    if (read_i && !state_q.rd_pend) begin
      state_d.rdata = 32'h0000_0000;
      if (addr_ok) begin
        case (idx)
          anx_pkg::EXPANSION_IDX:    state_d.rdata[15:0] = exp_word;
          anx_pkg::PARTNER_ABIL_IDX: state_d.rdata[15:0] = state_q.partner;
          anx_pkg::CONTROL_IDX:      state_d.rdata[anx_pkg::OVERRIDE_BIT] = state_q.override;
          anx_pkg::IRQ_STATUS_IDX:   state_d.rdata[2:0] = state_q.irq_stat;
          anx_pkg::IRQ_MASK_IDX:     state_d.rdata[2:0] = state_q.irq_mask;
          default:                   state_d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q <= '0;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  a_fault_latch: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && pd_fault_i |=> state_q.pd_fault)
    else $error("fault flag did not latch");
  a_fault_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && state_q.pd_fault && !exp_read |=> state_q.pd_fault)
    else $error("fault flag dropped without read");
  a_page_set: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && page_rx_i |=> state_q.page_rx)
    else $error("page flag not set");
  a_page_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && exp_read && !page_rx_i |=> !state_q.page_rx)
    else $error("page flag not cleared by read");
  a_partner_np: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && page_rx_i |=> state_q.lp_np == $past(page_word_i[15]))
    else $error("partner next page mismatch");
  a_partner_load: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && page_rx_i |=> state_q.partner == $past(page_word_i))
    else $error("partner word not loaded");
  a_an_set: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && flp_valid_i |=> state_q.lp_an)
    else $error("negotiation able not set");
  a_rsvd_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    read_i && !waitrequest_o && addr_ok && idx == anx_pkg::EXPANSION_IDX
      |-> readdata_o[15:5] == 11'h000 && readdata_o[2])
    else $error("expansion readback wrong");
  a_rsvd_guard: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && !state_q.override |=> $stable(state_q.rsvd))
    else $error("reserved bits changed while protected");
  a_reset_vals: assert property (@(posedge clock_i)
    rst_i |=> !state_q.pd_fault && !state_q.page_rx && !state_q.lp_an && !state_q.lp_np)
    else $error("reset values wrong");
  a_read_wait: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && read_i && waitrequest_o ##1 (read_i && ce_i) |-> !waitrequest_o)
    else $error("read not answered in one cycle");

endmodule
`default_nettype wire

/* File: rtl/anx_pkg.sv */
package anx_pkg;
  // Register word indices; byte address is four times the index.
  localparam logic [3:0]  EXPANSION_IDX    = 4'h6;
  localparam logic [3:0]  PARTNER_ABIL_IDX = 4'h5;
  localparam logic [3:0]  CONTROL_IDX      = 4'h8;
  localparam logic [3:0]  IRQ_STATUS_IDX   = 4'h9;
  localparam logic [3:0]  IRQ_MASK_IDX     = 4'hA;
  // Expansion register fields, plus the partner next-page and control override bits.
  localparam int          PD_FAULT_BIT     = 4;
  localparam int          LP_NP_BIT        = 3;
  localparam int          LOCAL_NP_BIT     = 2;
  localparam int          PAGE_RX_BIT      = 1;
  localparam int          LP_AN_BIT        = 0;
  localparam int          RSVD_LSB         = 5;
  localparam int          RSVD_W           = 11;
  localparam int          PARTNER_NP_BIT   = 15;
  localparam int          OVERRIDE_BIT     = 15;
  // Interrupt status bits.
  localparam int          IRQ_FAULT_BIT    = 0;
  localparam int          IRQ_PAGE_BIT     = 1;
  localparam int          IRQ_AN_BIT       = 2;
  localparam int          IRQ_W            = 3;
  // Reset values.
  localparam logic [15:0] WORD_RESET       = 16'h0000;
  localparam logic [2:0]  IRQ_RESET        = 3'h0;
  localparam logic        LOCAL_NP_RESET   = 1'b1;
  // Reads answer one cycle after they are first presented, in the cycle they are taken.
  localparam int          READ_WAIT_CYCLES = 1;
endpackage

/* File: tb/anx_sme_model.sv */
`timescale 1ns/1ns
`default_nettype none
module anx_sme_model (
  // Clock and slave answer
  input  wire logic        clock_i,
  input  wire logic        waitrequest_i,
  input  wire logic [31:0] readdata_i,
  // Master request
  output logic      [5:0]  address_o,
  output logic             read_o,
  output logic             write_o,
  output logic      [31:0] writedata_o,
  output logic      [3:0]  byteenable_o
);
  initial begin
    address_o = 6'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0000_0000;
    byteenable_o = 4'hF;
  end
  // Each transfer starts on a fresh edge, so no signal is driven twice in one step.
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                      input logic keep, output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0000_0000;
    @(posedge clock_i);
    address_o <= a;
    writedata_o <= (keep && a == 6'h18) ? (wd & 32'h0000_001F) : wd;
    read_o <= !wr;
    write_o <= wr;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clock_i);
      ok = !waitrequest_i;
      rd = readdata_i;
    end
    read_o <= 1'b0;
    write_o <= 1'b0;
    writedata_o <= ~writedata_o;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_autoneg_expansion_status.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_autoneg_expansion_status;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        stall = 1'b0;
  logic        pd_fault_i = 1'b0;
  logic        flp_valid_i = 1'b0;
  logic        page_rx_i = 1'b0;
  logic [15:0] page_word_i = 16'h0000;
  logic [5:0]  address;
  logic        read, write, waitrequest, irq;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable;
  logic [15:0] w;
  int          err_total = 0;
  int          cmp_count = 0;
  always #25 clock_i = ~clock_i;
  // Random enable gaps only while bus reads run, so event pulses are never lost.
  always @(posedge clock_i) ce_i <= !stall || ($urandom_range(1) != 0);
  anx_sme_model sme_u (.clock_i(clock_i), .waitrequest_i(waitrequest), .readdata_i(readdata),
    .address_o(address), .read_o(read), .write_o(write), .writedata_o(writedata),
    .byteenable_o(byteenable));
  anx_expansion_status dut_u (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
    .address_i(address), .read_i(read), .write_i(write), .writedata_i(writedata),
    .byteenable_i(byteenable), .readdata_o(readdata), .waitrequest_o(waitrequest),
    .pd_fault_i(pd_fault_i), .flp_valid_i(flp_valid_i), .page_rx_i(page_rx_i),
    .page_word_i(page_word_i), .irq_o(irq));
  // The local next-page bit is forced, since the block always advertises it.
  function automatic logic [31:0] exp_word(input logic [4:0] v);
    return {27'h000_0000, v | 5'b00100};
  endfunction
  task automatic summarize();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    logic ok;
    sme_u.xfer(wr, a, wd, !(wr && a == 6'h18 && wd[15]), rd, ok);
    if (!ok) begin
      err_total++;
      $display("BAD %0t bus timeout", $time);
      summarize();
    end
  endtask
  task automatic ev(input logic [2:0] k);
    @(posedge clock_i);
    {flp_valid_i, page_rx_i, pd_fault_i} <= k;
    @(posedge clock_i);
    {flp_valid_i, page_rx_i, pd_fault_i} <= 3'h0;
  endtask
  task automatic chk_irq(input logic e);
    repeat (2) @(negedge clock_i);
    cmp({31'h0000_0000, irq}, {31'h0000_0000, e}, "irq level");
  endtask
  initial begin
    void'($urandom(32'h0575));
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    bus(1'b0, 6'h18, 32'h0000_0000);
    cmp(rd, exp_word(5'b00000), "reset value");
    chk_irq(1'b0);
    bus(1'b0, 6'h3C, 32'h0000_0000);
    cmp(rd, 32'h0000_0000, "unmapped");
    ev(3'b100);
    bus(1'b0, 6'h18, 32'h0000_0000);
    cmp(rd, exp_word(5'b00001), "partner able");
    $display("test reset and partner able done");
    for (int i = 0; i < 6; i++) begin
      w = 16'($urandom());
      if (i < 2) w[15] = i[0];
      page_word_i <= w;
      ev(3'b010);
      stall <= 1'b1;
      bus(1'b0, 6'h14, 32'h0000_0000);
      cmp(rd & 32'h0000_E3FF, {16'h0000, w & 16'hE3FF}, "partner word");
      bus(1'b0, 6'h18, 32'h0000_0000);
      cmp(rd, exp_word({1'b0, w[15], 3'b011}), "page set");
      bus(1'b0, 6'h18, 32'h0000_0000);
      cmp(rd, exp_word({1'b0, w[15], 3'b001}), "page cleared");
      stall <= 1'b0;
    end
    $display("test pages done");
    ev(3'b001);
    bus(1'b0, 6'h18, 32'h0000_0000);
    cmp(rd, exp_word({1'b1, w[15], 3'b001}), "fault latched");
    bus(1'b0, 6'h18, 32'h0000_0000);
    cmp(rd, exp_word({1'b0, w[15], 3'b001}), "fault cleared");
    bus(1'b1, 6'h18, 32'h0000_FFE0);
    bus(1'b0, 6'h18, 32'h0000_0000);
    cmp(rd, exp_word({1'b0, w[15], 3'b001}), "reserved locked");
    bus(1'b1, 6'h20, 32'h0000_8000);
    bus(1'b1, 6'h18, 32'h0000_FFE0);
    bus(1'b0, 6'h18, 32'h0000_0000);
    cmp(rd, exp_word({1'b0, w[15], 3'b001}), "reserved override");
    $display("test fault and reserved done");
    bus(1'b1, 6'h24, 32'h0000_0007);
    bus(1'b1, 6'h28, 32'h0000_0007);
    chk_irq(1'b0);
    ev(3'b010);
    chk_irq(1'b1);
    bus(1'b1, 6'h28, 32'h0000_0000);
    chk_irq(1'b0);
    bus(1'b1, 6'h28, 32'h0000_0002);
    chk_irq(1'b1);
    bus(1'b1, 6'h24, 32'h0000_0002);
    chk_irq(1'b0);
    bus(1'b0, 6'h24, 32'h0000_0000);
    cmp(rd, 32'h0000_0000, "status cleared");
    $display("test interrupt done");
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    bus(1'b0, 6'h18, 32'h0000_0000);
    cmp(rd, exp_word(5'b00000), "mid-run reset");
    $display("test mid-run reset done");
    summarize();
  end
endmodule
`default_nettype wire
